//--- scs_defs.svh
/*
  Constants of the system clock sync unit: offsets, fields, ranges, timing.
  Assumes inclusion by bare name; all values are plain decimals or expressions of them unless sized.
*/
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

// ==========================================================
// timing
`define SCS_CLK_HZ          125000000
`define SCS_TICK_MS         1
`define SCS_TICK_CYCLES     (`SCS_CLK_HZ / 1000 * `SCS_TICK_MS)
`define SCS_DAY_MS          86400000
`define SCS_MINUTE_MS       60000
`define SCS_HALF_MINUTE_MS  30000
`define SCS_STEP_LIMIT_S    4
`define SCS_STEP_LIMIT_MS   (`SCS_STEP_LIMIT_S * 1000)
`define SCS_LOSS_MIN_X10    15
`define SCS_LOSS_MS         (`SCS_LOSS_MIN_X10 * 6000)

// ==========================================================
// ranges
`define SCS_DEV_REPORT_MAX  32767
`define SCS_FILT_MAX        125
`define SCS_SRC_OFS_MAX_MS  10000000
`define SCS_ZONE_MAX        1500
`define SCS_ZONE_STEP_MS    36000
`define SCS_SUMMER_MS       3600000
`define SCS_AA_MAX_MS       1000000
`define SCS_PULSE_LINES     24
`define SCS_PULSE_NONE      8'hff

// ==========================================================
// register offsets
`define SCS_ADDR_CONFIG     8'h00
`define SCS_ADDR_ZONE       8'h04
`define SCS_ADDR_SRC_OFS    8'h08
`define SCS_ADDR_AUTO_ADJ   8'h0c
`define SCS_ADDR_TIME       8'h10
`define SCS_ADDR_STATUS     8'h14
`define SCS_ADDR_DEV        8'h18
`define SCS_ADDR_FILT_DEV   8'h1c

// ==========================================================
// field positions
`define SCS_CFG_STYLE_LSB   0
`define SCS_CFG_SUMMER_BIT  4
`define SCS_CFG_SEL_LSB     8
`define SCS_AA_LEAD_BIT     31
`define SCS_STAT_CNT_LSB    16

`endif

//--- scs_pkg.sv
/*
  Types of the system clock sync unit.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package scs_pkg;

  typedef enum logic [3:0] {
    SRC_INTERNAL,
    SRC_DI,
    SRC_SNTP,
    SRC_SERIAL_PROTO,
    SRC_MODBUS,
    SRC_MODBUS_TCP,
    SRC_PROFIBUS,
    SRC_IEC101,
    SRC_IEC103,
    SRC_DNP3,
    SRC_IRIG_B003,
    SRC_IRIG_B004
  } scs_src_t;

  typedef enum logic [1:0] {
    STYLE_YMD,
    STYLE_DMY,
    STYLE_MDY
  } scs_style_t;

endpackage

//--- scs_dev_if.sv
/*
  Carrier between the sync unit and its deviation calculator.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface scs_dev_if;
  logic               strobe;
  logic        [26:0] sys_ms;
  logic        [26:0] ref_ms;
  logic               done;
  logic               big;
  logic        [26:0] ref_q;
  logic signed [15:0] dev_rep;
  logic signed [7:0]  filt;

  modport calc (input strobe, sys_ms, ref_ms, output done, big, ref_q, dev_rep, filt);
  modport user (output strobe, sys_ms, ref_ms, input done, big, ref_q, dev_rep, filt);
endinterface

`default_nettype wire

//--- scs_dev_calc.sv
/*
  Deviation calculator: signed system-minus-source difference, report and filter.
  Assumes one strobe per sync event and times within one day.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scs_defs.svh"

module scs_dev_calc (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // carrier
  scs_dev_if.calc   dv
);
  import scs_pkg::*;

  logic signed [28:0] diff;
  logic signed [28:0] norm;
  logic signed [28:0] avg;
  logic signed [28:0] mag;
  logic signed [28:0] prev_reg;
  logic               done_reg;
  logic               big_reg;
  logic        [26:0] ref_reg;
  logic signed [15:0] dev_reg;
  logic signed [7:0]  filt_reg;

  function automatic logic signed [28:0] f_sat(input logic signed [28:0] v, input logic signed [28:0] lim);
    if (v > lim)
      return lim;
    else if (v < -lim)
      return -lim;
    else
      return v;
  endfunction

  // ==========================================================
  // difference folded into plus or minus half a day
  always_comb
  begin
    diff = $signed({2'b00, dv.sys_ms}) - $signed({2'b00, dv.ref_ms});
    norm = diff;
    if (diff > $signed(29'(`SCS_DAY_MS / 2)))
      norm = diff - $signed(29'(`SCS_DAY_MS));
    else if (diff < -$signed(29'(`SCS_DAY_MS / 2)))
      norm = diff + $signed(29'(`SCS_DAY_MS));
    mag = (norm < 0) ? -norm : norm;
    avg = (norm + prev_reg) >>> 1;
  end

  // ==========================================================
  // registered results
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      done_reg <= 1'b0;
      big_reg  <= 1'b0;
      ref_reg  <= 27'h0;
      dev_reg  <= 16'sh0;
      filt_reg <= 8'sh0;
      prev_reg <= 29'sh0;
    end
    else
    begin
      done_reg <= dv.strobe;
      if (dv.strobe)
      begin
        ref_reg  <= dv.ref_ms;
        big_reg  <= mag >= $signed(29'(`SCS_STEP_LIMIT_MS));
        dev_reg  <= 16'(f_sat(norm, 29'(`SCS_DEV_REPORT_MAX)));
        if (mag >= $signed(29'(`SCS_STEP_LIMIT_MS)))
        begin
          filt_reg <= 8'(f_sat(norm, 29'(`SCS_FILT_MAX)));
          prev_reg <= 29'sh0;
        end
        else
        begin
          filt_reg <= 8'(f_sat(avg, 29'(`SCS_FILT_MAX)));
          prev_reg <= norm;
        end
      end
    end
  end

  assign dv.done    = done_reg;
  assign dv.big     = big_reg;
  assign dv.ref_q   = ref_reg;
  assign dv.dev_rep = dev_reg;
  assign dv.filt    = filt_reg;

endmodule

`default_nettype wire

//--- scs_sync_unit.sv
/*
  System clock sync unit: time of day in ms, disciplined by minute pulses,
  protocol messages and time code, with learned 1 ms auto-adjust.
  Assumes messages and virtual lines come from logic on core_clk_i and that
  digital pulse lines and the time-code option strap are asynchronous pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scs_defs.svh"

module scs_sync_unit #(
  parameter int TICK_CYCLES = `SCS_TICK_CYCLES,
  parameter int LOSS_MS     = `SCS_LOSS_MS
) (
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_i,
  // register port
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [31:0]          reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic      [31:0]          reg_rdata_o,
  // minute pulse lines
  input  wire logic [7:0]           pulse_di_i,
  input  wire logic [15:0]          pulse_virt_i,
  // sync messages
  input  wire logic                 msg_valid_i,
  input  wire scs_pkg::scs_src_t    msg_source_i,
  input  wire logic [26:0]          msg_time_ms_i,
  input  wire logic                 irig_fitted_i,
  // status
  output logic [26:0]               time_of_day_ms_o,
  output scs_pkg::scs_src_t         sync_source_o,
  output scs_pkg::scs_style_t       date_style_o,
  output logic                      ms_tick_o
);
  import scs_pkg::*;

  scs_dev_if dv ();

  logic [8:0]         pin_s1;
  logic [8:0]         pin_s2;
  logic [8:0]         pin_s3;
  logic [8:0]         pin_level_reg;
  logic [16:0]        tick_cnt_reg;
  logic               tick_reg;
  logic [26:0]        time_reg;
  logic [15:0]        debt_reg;
  logic               skip_reg;
  scs_style_t         style_reg;
  logic               summer_time_enable;
  logic [7:0]         pulse_input_select;
  logic signed [11:0] zone_offset_hours;
  logic signed [24:0] source_offset_seconds;
  logic [19:0]        auto_adjust_interval;
  logic               drift_sign;
  logic [19:0]        aa_cnt_reg;
  logic [19:0]        elapsed_reg;
  scs_src_t           active_sync_source;
  logic [15:0]        sync_event_count;
  logic [16:0]        loss_cnt_reg;
  logic               pulse_prev_reg;
  logic [31:0]        rdata_reg;
  logic               tick_out_reg;

  logic [23:0]        lines;
  logic               pulse_level;
  logic               pulse_edge;
  logic               msg_ok;
  logic               event_fire;
  logic [15:0]        min_rem;
  logic signed [33:0] ofs;
  logic signed [33:0] ref_raw;
  logic               aa_fire;
  logic               hold;
  logic [7:0]         slew_fwd;
  logic [7:0]         slew_back;
  logic [9:0]         adv;
  logic [16:0]        debt_sum;
  logic               wr_time;

  function automatic logic [26:0] f_wrap(input logic signed [33:0] v);
    logic signed [33:0] r;
    r = v;
    if (r < 0)
      r = r + $signed(34'(`SCS_DAY_MS));
    else if (r >= $signed(34'(`SCS_DAY_MS)))
      r = r - $signed(34'(`SCS_DAY_MS));
    return r[26:0];
  endfunction

  function automatic logic signed [31:0] f_clamp(input logic signed [31:0] v, input logic signed [31:0] lim);
    if (v > lim)
      return lim;
    else if (v < -lim)
      return -lim;
    else
      return v;
  endfunction

  function automatic logic f_wr(input logic [7:0] a);
    return reg_wr_i && (reg_addr_i == a);
  endfunction

  // ==========================================================
  // pin synchronisers: strap on top, digital lines below
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      pin_s1        <= 9'h0;
      pin_s2        <= 9'h0;
      pin_s3        <= 9'h0;
      pin_level_reg <= 9'h0;
    end
    else
    begin
      pin_s1 <= {irig_fitted_i, pulse_di_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int i = 0; i < 9; i++)
        if (pin_s2[i] == pin_s3[i])
          pin_level_reg[i] <= pin_s3[i];
    end
  end

  // ==========================================================
  // 1 ms tick divider
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      tick_cnt_reg <= 17'h0;
      tick_reg     <= 1'b0;
    end
    else if (tick_cnt_reg == 17'(TICK_CYCLES - 1))
    begin
      tick_cnt_reg <= 17'h0;
      tick_reg     <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 17'h1;
      tick_reg     <= 1'b0;
    end
  end

  // ==========================================================
  // event detection and reference time
  always_comb
  begin
    lines       = {pulse_virt_i, pin_level_reg[7:0]};
    pulse_level = (pulse_input_select < 8'(`SCS_PULSE_LINES)) ? lines[pulse_input_select[4:0]] : 1'b0;
    pulse_edge  = pulse_level && !pulse_prev_reg;
    msg_ok      = msg_valid_i && (msg_source_i != SRC_INTERNAL) && (msg_source_i != SRC_DI)
                  && (msg_source_i <= SRC_IRIG_B004)
                  && (((msg_source_i != SRC_IRIG_B003) && (msg_source_i != SRC_IRIG_B004))
                      || pin_level_reg[8]);
    event_fire  = msg_ok || pulse_edge;
    min_rem     = 16'(time_reg % 27'(`SCS_MINUTE_MS));
    ofs         = 34'(source_offset_seconds);
    if (msg_source_i == SRC_SNTP)
    begin
      ofs = ofs + 34'(zone_offset_hours) * $signed(34'(`SCS_ZONE_STEP_MS));
      if (summer_time_enable)
        ofs = ofs + $signed(34'(`SCS_SUMMER_MS));
    end
    if (msg_ok)
      ref_raw = $signed({7'h0, msg_time_ms_i}) + ofs;
    else if (min_rem >= 16'(`SCS_HALF_MINUTE_MS))
      ref_raw = $signed({7'h0, time_reg}) - $signed({18'h0, min_rem}) + $signed(34'(`SCS_MINUTE_MS));
    else
      ref_raw = $signed({7'h0, time_reg}) - $signed({18'h0, min_rem});
  end

  assign dv.strobe = event_fire;
  assign dv.sys_ms = time_reg;
  assign dv.ref_ms = f_wrap(ref_raw);

  scs_dev_calc u_dev (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .dv         (dv.calc)
  );

  // ==========================================================
  // clock advance: tick, auto-adjust, slewing
  always_comb
  begin
    wr_time   = f_wr(`SCS_ADDR_TIME);
    aa_fire   = tick_reg && (auto_adjust_interval != 20'h0) && ((aa_cnt_reg + 20'h1) >= auto_adjust_interval);
    hold      = tick_reg && (debt_reg != 16'h0) && skip_reg;
    slew_fwd  = (dv.done && !dv.big && (dv.filt < 0)) ? 8'(-dv.filt) : 8'h0;
    slew_back = (dv.done && !dv.big && (dv.filt > 0)) ? 8'(dv.filt) : 8'h0;
    adv       = {9'h0, tick_reg && !hold} + {9'h0, aa_fire && !drift_sign} + {2'h0, slew_fwd};
    debt_sum  = {1'b0, debt_reg} - {16'h0, hold} + {16'h0, aa_fire && drift_sign} + {9'h0, slew_back};
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      time_reg <= 27'h0;
      debt_reg <= 16'h0;
      skip_reg <= 1'b0;
    end
    else if (wr_time)
    begin
      time_reg <= f_wrap($signed({2'b00, reg_wdata_i}));
      debt_reg <= 16'h0;
    end
    else if (dv.done && dv.big)
    begin
      time_reg <= dv.ref_q;
      debt_reg <= 16'h0;
    end
    else
    begin
      time_reg <= f_wrap($signed({7'h0, time_reg}) + $signed({24'h0, adv}));
      debt_reg <= debt_sum[16] ? 16'hffff : debt_sum[15:0];
      if (tick_reg && (debt_reg != 16'h0))
        skip_reg <= !skip_reg;
    end
  end

  // ==========================================================
  // drift learning and auto-adjust timer
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      auto_adjust_interval <= 20'h0;
      drift_sign           <= 1'b0;
      aa_cnt_reg           <= 20'h0;
      elapsed_reg          <= 20'h0;
    end
    else
    begin
      if (aa_fire)
        aa_cnt_reg <= 20'h0;
      else if (tick_reg)
        aa_cnt_reg <= aa_cnt_reg + 20'h1;
      if (dv.done)
        elapsed_reg <= 20'h0;
      else if (tick_reg && (elapsed_reg < 20'(`SCS_AA_MAX_MS)))
        elapsed_reg <= elapsed_reg + 20'h1;
      if (f_wr(`SCS_ADDR_AUTO_ADJ))
      begin
        auto_adjust_interval <= 20'(f_clamp($signed({12'h0, reg_wdata_i[19:0]}), 32'(`SCS_AA_MAX_MS)));
        drift_sign           <= reg_wdata_i[`SCS_AA_LEAD_BIT];
      end
      else if (dv.done && !dv.big && (dv.filt != 0))
      begin
        if (auto_adjust_interval == 20'h0)
        begin
          auto_adjust_interval <= elapsed_reg;
          drift_sign           <= dv.filt > 0;
        end
        else if ((dv.filt > 0) == drift_sign)
          auto_adjust_interval <= auto_adjust_interval - (auto_adjust_interval >> 3);
        else if (auto_adjust_interval > (20'(`SCS_AA_MAX_MS) - (auto_adjust_interval >> 3)))
          auto_adjust_interval <= 20'h0;
        else
          auto_adjust_interval <= auto_adjust_interval + (auto_adjust_interval >> 3);
      end
    end
  end

  // ==========================================================
  // source tracking, loss timeout, event counting
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      active_sync_source <= SRC_INTERNAL;
      sync_event_count   <= 16'h0;
      loss_cnt_reg       <= 17'h0;
      pulse_prev_reg     <= 1'b0;
    end
    else
    begin
      pulse_prev_reg <= pulse_level;
      if (event_fire)
      begin
        active_sync_source <= msg_ok ? msg_source_i : SRC_DI;
        sync_event_count   <= sync_event_count + 16'h1;
        loss_cnt_reg       <= 17'h0;
      end
      else if (tick_reg && (active_sync_source != SRC_INTERNAL))
      begin
        if (loss_cnt_reg >= 17'(LOSS_MS - 1))
        begin
          active_sync_source <= SRC_INTERNAL;
          loss_cnt_reg       <= 17'h0;
        end
        else
          loss_cnt_reg <= loss_cnt_reg + 17'h1;
      end
    end
  end

  // ==========================================================
  // settings
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      style_reg             <= STYLE_YMD;
      summer_time_enable    <= 1'b0;
      pulse_input_select    <= `SCS_PULSE_NONE;
      zone_offset_hours     <= 12'sh0;
      source_offset_seconds <= 25'sh0;
    end
    else
    begin
      if (f_wr(`SCS_ADDR_CONFIG))
      begin
        if (reg_wdata_i[`SCS_CFG_STYLE_LSB +: 2] != 2'h3)
          style_reg <= scs_style_t'(reg_wdata_i[`SCS_CFG_STYLE_LSB +: 2]);
        summer_time_enable <= reg_wdata_i[`SCS_CFG_SUMMER_BIT];
        pulse_input_select <= reg_wdata_i[`SCS_CFG_SEL_LSB +: 8];
      end
      if (f_wr(`SCS_ADDR_ZONE))
        zone_offset_hours <= 12'(f_clamp($signed(reg_wdata_i), 32'(`SCS_ZONE_MAX)));
      if (f_wr(`SCS_ADDR_SRC_OFS))
        source_offset_seconds <= 25'(f_clamp($signed(reg_wdata_i), 32'(`SCS_SRC_OFS_MAX_MS)));
    end
  end

  // ==========================================================
  // read data, one cycle after the strobe
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      rdata_reg <= 32'h0;
    else if (!reg_rd_i)
      rdata_reg <= 32'h0;
    else
      case (reg_addr_i)
        `SCS_ADDR_CONFIG:   rdata_reg <= {16'h0, pulse_input_select, 3'h0, summer_time_enable, 2'h0, style_reg};
        `SCS_ADDR_ZONE:     rdata_reg <= 32'(zone_offset_hours);
        `SCS_ADDR_SRC_OFS:  rdata_reg <= 32'(source_offset_seconds);
        `SCS_ADDR_AUTO_ADJ: rdata_reg <= {drift_sign, 11'h0, auto_adjust_interval};
        `SCS_ADDR_TIME:     rdata_reg <= {5'h0, time_reg};
        `SCS_ADDR_STATUS:   rdata_reg <= {sync_event_count, 12'h0, active_sync_source};
        `SCS_ADDR_DEV:      rdata_reg <= 32'(dv.dev_rep);
        `SCS_ADDR_FILT_DEV: rdata_reg <= 32'(dv.filt);
        default:            rdata_reg <= 32'h0;
      endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      tick_out_reg <= 1'b0;
    else
      tick_out_reg <= tick_reg;
  end

  assign reg_rdata_o      = rdata_reg;
  assign time_of_day_ms_o = time_reg;
  assign sync_source_o    = active_sync_source;
  assign date_style_o     = style_reg;
  assign ms_tick_o        = tick_out_reg;

endmodule

`default_nettype wire

//--- scs_sync_unit_sva.sv
/*
  Port checker of the system clock sync unit.
  Assumes a bind onto scs_sync_unit, one clock, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module scs_sync_unit_sva
  import scs_pkg::*;
#(
  parameter int LOSS_MS = 90000
) (
  // clock and reset
  input wire logic                core_clk_i,
  input wire logic                rst_i,
  // register port
  input wire logic [7:0]          reg_addr_i,
  input wire logic [31:0]         reg_wdata_i,
  input wire logic                reg_wr_i,
  input wire logic                reg_rd_i,
  input wire logic [31:0]         reg_rdata_o,
  // messages and status
  input wire logic                msg_valid_i,
  input wire scs_pkg::scs_src_t   msg_source_i,
  input wire logic [26:0]         time_of_day_ms_o,
  input wire scs_pkg::scs_src_t   sync_source_o,
  input wire scs_pkg::scs_style_t date_style_o,
  input wire logic                ms_tick_o
);
  import scs_pkg::*;

  // ==========================================================
  // ms ticks since the last message, held at zero while the source is SRC_DI
  logic [31:0] quiet_reg;
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || msg_valid_i || sync_source_o == SRC_DI)
      quiet_reg <= 32'h0;
    else if (ms_tick_o)
      quiet_reg <= quiet_reg + 32'h1;
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside read cycle");
  a_src_follow: assert property (
    msg_valid_i && msg_source_i inside {[SRC_SNTP:SRC_DNP3]} |=> sync_source_o == $past(msg_source_i))
    else $error("source not taken from message");
  a_src_cause: assert property (
    !$stable(sync_source_o) && sync_source_o != SRC_INTERNAL && sync_source_o != SRC_DI
    |-> $past(msg_valid_i) && sync_source_o == $past(msg_source_i))
    else $error("source changed without arrival");
  a_loss_internal: assert property (quiet_reg >= LOSS_MS + 2 |-> sync_source_o inside {SRC_INTERNAL, SRC_DI})
    else $error("no fallback to internal");
  a_style_legal: assert property (date_style_o != 2'h3)
    else $error("illegal date style");
  a_style_write: assert property (
    reg_wr_i && reg_addr_i == 8'h00 && reg_wdata_i[1:0] != 2'h3 |=> date_style_o == $past(reg_wdata_i[1:0]))
    else $error("date style not written");
  a_status_read: assert property (
    reg_rd_i && reg_addr_i == 8'h14 |=> reg_rdata_o[3:0] == $past(sync_source_o) && reg_rdata_o[15:4] == 12'h0)
    else $error("status source field wrong");
  a_tick_single: assert property (ms_tick_o |=> !ms_tick_o)
    else $error("tick longer than one cycle");
  a_time_write: assert property (
    reg_wr_i && reg_addr_i == 8'h10 && reg_wdata_i < 32'd86400000
    |=> time_of_day_ms_o - $past(reg_wdata_i[26:0]) <= 27'h1)
    else $error("time write not applied");
  a_time_range: assert property (time_of_day_ms_o < 27'd86400000)
    else $error("time beyond one day");
endmodule

`default_nettype wire

//--- scs_sync_master.sv
/*
  Sync master model: protocol messages and minute pulses.
  Assumes tasks called from the bench, one at a time per kind.
*/
`timescale 1ns/1ps
`default_nettype none

module scs_sync_master
  import scs_pkg::*;
#(
  parameter int TICK_CYCLES = 8
) (
  // clock
  input  wire logic              core_clk_i,
  // pulse lines
  output logic [7:0]             pulse_di_o,
  output logic [15:0]            pulse_virt_o,
  // messages
  output logic                   msg_valid_o,
  output scs_pkg::scs_src_t      msg_source_o,
  output logic [26:0]            msg_time_o
);
  import scs_pkg::*;

  initial
  begin
    pulse_di_o = 8'h0;
    pulse_virt_o = 16'h0;
    msg_valid_o = 1'b0;
    msg_source_o = SRC_INTERNAL;
    msg_time_o = 27'h0;
  end

  // one-cycle message, time field scrambled afterwards
  task automatic send(input scs_src_t src, input logic [26:0] t);
    @(posedge core_clk_i);
    msg_valid_o <= 1'b1;
    msg_source_o <= src;
    msg_time_o <= t;
    @(posedge core_clk_i);
    msg_valid_o <= 1'b0;
    msg_time_o <= ~t;
  endtask

  // minute pulse held at least 50 ms
  task automatic pulse(input logic [4:0] line);
    @(posedge core_clk_i);
    if (line < 5'd8)
      pulse_di_o[line[2:0]] <= 1'b1;
    else
      pulse_virt_o[4'(line - 5'd8)] <= 1'b1;
    repeat (50 * TICK_CYCLES) @(posedge core_clk_i);
    pulse_di_o <= 8'h0;
    pulse_virt_o <= 16'h0;
  endtask
endmodule

`default_nettype wire

//--- system_clock_sync_unit_bench.sv
/*
  Self-checking bench of the system clock sync unit.
  Assumes the sync master model and the port checker beside it.
*/
`timescale 1ns/1ps
`default_nettype none

module system_clock_sync_unit_bench;
  import scs_pkg::*;
  localparam int TICK = 8;
  localparam int LOSS = 20;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic irig_fitted_i = 1'b0;
  logic [31:0] reg_rdata_o, v;
  logic [7:0] pdi, seed;
  logic [15:0] pvirt;
  logic mval, tick;
  logic [26:0] mtime, tod, t0;
  scs_src_t msrc, src, exp_src;
  scs_style_t style;
  int failures = 0, check_count = 0;
  int cycles = 0, cnt = 0, ticks = 0;
  logic [7:0] wa [4] = '{8'h4, 8'h4, 8'h8, 8'hc};
  logic [31:0] wd [4] = '{32'd2000, -32'sd2000, 32'd20000000, 32'h000fffff};
  logic [31:0] we [4] = '{32'd1500, -32'sd1500, 32'd10000000, 32'h000f4240};
  logic [4:0] pl [4] = '{5'd2, 5'd13, 5'd2, 5'd2};
  logic [7:0] ps [4] = '{8'h2, 8'hd, 8'h2, 8'hff};
  logic [26:0] pt [4] = '{27'd160000, 27'd160000, 27'd122000, 27'd160000};
  logic [26:0] pe [4] = '{27'd180000, 27'd180000, 27'd122000, 27'd160000};

  always #4 core_clk_i = ~core_clk_i;

  scs_sync_master #(.TICK_CYCLES(TICK)) m (.core_clk_i(core_clk_i), .pulse_di_o(pdi), .pulse_virt_o(pvirt),
    .msg_valid_o(mval), .msg_source_o(msrc), .msg_time_o(mtime));
  scs_sync_unit #(.TICK_CYCLES(TICK), .LOSS_MS(LOSS)) uut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .pulse_di_i(pdi), .pulse_virt_i(pvirt), .msg_valid_i(mval),
    .msg_source_i(msrc), .msg_time_ms_i(mtime), .irig_fitted_i(irig_fitted_i), .time_of_day_ms_o(tod),
    .sync_source_o(src), .date_style_o(style), .ms_tick_o(tick));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [31:0] in_rng(input logic [31:0] x, lo, hi);
    return {31'h0, x >= lo && x <= hi};
  endfunction
  // reference of a message: offset, then zone and summer hour for network time
  function automatic logic [31:0] ref_of(input logic [26:0] t, input int ofs, zone, input bit sntp);
    return 32'((t + ofs + (sntp ? zone * 36000 + 3600000 : 0)) % 86400000);
  endfunction

  task automatic check(input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask
  task automatic settle();
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      give_verdict();
    end
  end

  initial
  begin
    seed = 8'd93;
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(8'h00, v);
    check(v, 32'h0000ff00);
    rd(8'h14, v);
    check(v, 32'h0);
    rd(8'h20, v);
    check(v, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(wa[i], wd[i]);
      rd(wa[i], v);
      check(v, we[i]);
    end
    for (int i = 3; i >= 0; i--)
    begin
      wr(8'h00, 32'h0000ff00 | i);
      #1;
      check({30'h0, style}, i == 3 ? 32'h0 : i);
    end
    wr(8'h0c, 32'h0);
    wr(8'h08, 32'd500);
    wr(8'h04, 32'd100);
    wr(8'h00, 32'h0000ff10);
    wr(8'h10, 32'h0);
    m.send(SRC_SNTP, 27'd1000000);
    settle();
    check(in_rng({5'h0, tod}, ref_of(27'd1000000, 500, 100, 1), ref_of(27'd1000000, 500, 100, 1) + 2), 1);
    rd(8'h18, v);
    check(v, -32'sd32767);
    rd(8'h1c, v);
    check(v, -32'sd125);
    rd(8'h14, v);
    check(v, {16'd1, 12'h0, SRC_SNTP});
    m.send(SRC_MODBUS, 27'd2000000);
    settle();
    check(in_rng({5'h0, tod}, ref_of(27'd2000000, 500, 100, 0), ref_of(27'd2000000, 500, 100, 0) + 2), 1);
    t0 = tod;
    m.send(SRC_MODBUS, t0 - 27'd600);
    for (int i = 0; i < 200; i++)
    begin
      t0 = tod;
      @(posedge core_clk_i);
      #1;
      check(in_rng({5'h0, tod}, {5'h0, t0}, {5'h0, t0} + 1), 1);
      ticks += tick;
    end
    check(ticks, 25);
    rd(8'h18, v);
    check(in_rng(v, 32'd100, 32'd101), 1);
    rd(8'h1c, v);
    check(v, 32'd50);
    cnt = 3;
    repeat ((LOSS + 3) * TICK) @(posedge core_clk_i);
    check({28'h0, src}, {28'h0, SRC_INTERNAL});
    m.send(SRC_IRIG_B003, tod - 27'd500);
    settle();
    check({28'h0, src}, {28'h0, SRC_INTERNAL});
    irig_fitted_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    for (int i = 0; i < 2; i++)
    begin
      exp_src = i == 0 ? SRC_IRIG_B003 : SRC_IRIG_B004;
      m.send(exp_src, tod - 27'd500);
      settle();
      check({28'h0, src}, {28'h0, exp_src});
      cnt++;
    end
    for (int i = 0; i < 12; i++)
    begin
      seed = lfsr(seed);
      if (seed[3])
        m.send(SRC_DI, tod - 27'd500);
      else
      begin
        exp_src = scs_src_t'(4'd2 + 4'(seed[2:0]));
        m.send(exp_src, tod - 27'd500);
        cnt++;
      end
      settle();
      check({28'h0, src}, {28'h0, exp_src});
    end
    rd(8'h14, v);
    check(v[31:16], cnt);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, {16'h0, ps[i], 8'h0});
      wr(8'h10, {5'h0, pt[i]});
      fork
        m.pulse(pl[i]);
      join_none
      repeat (10) @(posedge core_clk_i);
      #1;
      check(in_rng({5'h0, tod}, {5'h0, pe[i]}, {5'h0, pe[i]} + 3), 1);
      if (ps[i] != 8'hff)
        cnt++;
      wait fork;
      rd(8'h14, v);
      check(v[31:16], cnt);
    end
    wr(8'h0c, 32'h4);
    wr(8'h10, 32'h0);
    repeat (40 * TICK) @(posedge core_clk_i);
    check(in_rng({5'h0, tod}, 32'd48, 32'd52), 1);
    wr(8'h0c, 32'h80000004);
    wr(8'h10, 32'h0);
    repeat (40 * TICK) @(posedge core_clk_i);
    check(in_rng({5'h0, tod}, 32'd28, 32'd32), 1);
    give_verdict();
  end
endmodule

bind scs_sync_unit scs_sync_unit_sva #(.LOSS_MS(LOSS_MS)) chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .msg_valid_i(msg_valid_i), .msg_source_i(msg_source_i),
  .time_of_day_ms_o(time_of_day_ms_o), .sync_source_o(sync_source_o), .date_style_o(date_style_o),
  .ms_tick_o(ms_tick_o));

`default_nettype wire
